// [inc/tfs_pkg.sv]
// Shared constants and types of the traction fault supervisor
package tfs_pkg;

  // Clock rate
  localparam longint unsigned CLK_HZ = 100_000_000;

  // Sub-system fault inputs
  localparam int NUM_SS = 19;
  localparam int SS_W = 5;

  // Throttle scale in percent of maximum effort
  localparam int PCT_W = 7;
  localparam logic [PCT_W-1:0] PCT_0 = 7'h00;
  localparam logic [PCT_W-1:0] PCT_33 = 7'h21;
  localparam logic [PCT_W-1:0] PCT_67 = 7'h43;
  localparam logic [PCT_W-1:0] PCT_100 = 7'h64;
  localparam logic [PCT_W-1:0] THR_TOL_PCT = 7'h19;
  localparam int AUX_W = 2;

  // Delay from throttle defect to zero traction, seconds
  localparam longint unsigned DEFECT_DELAY_S = 2;
  localparam longint unsigned DEFECT_DELAY_CYC = DEFECT_DELAY_S * CLK_HZ;

  // Key inactivity limit, seconds
  localparam longint unsigned IDLE_TIMEOUT_S = 60;
  localparam longint unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;

  // Repeat window for second-priority faults, minutes
  localparam longint unsigned REPEAT_WIN_MIN = 30;
  localparam longint unsigned REPEAT_WIN_CYC = REPEAT_WIN_MIN * 64'd60 * CLK_HZ;

  // Effort ramp in degraded mode, kN per second, and full effort in kN
  localparam longint unsigned RAMP_KN_PER_S = 20;
  localparam longint unsigned EFFORT_MAX_KN = 500;
  localparam longint unsigned RAMP_STEP_CYC =
    (CLK_HZ * EFFORT_MAX_KN) / (64'd100 * RAMP_KN_PER_S);

  // Half period of the red lamp flash, milliseconds
  localparam longint unsigned FLASH_HALF_MS = 500;
  localparam longint unsigned FLASH_HALF_CYC = (FLASH_HALF_MS * CLK_HZ) / 64'd1000;

  typedef enum logic [2:0] {
    MSG_IDLE,
    MSG_P1,
    MSG_P2,
    MSG_ISOL,
    MSG_THR_ISOL,
    MSG_THR_P2,
    MSG_MENU
  } tfs_msg_kind_t;

  typedef struct packed {
    tfs_msg_kind_t kind;
    logic [SS_W-1:0] ss;
  } tfs_msg_t;

  typedef struct packed {
    logic degraded;
    logic [AUX_W-1:0] aux;
    logic [PCT_W-1:0] angle;
  } tfs_thr_t;

  typedef struct packed {
    logic ack;
    logic clear;
    logic menu;
    logic key;
  } tfs_keys_t;

endpackage : tfs_pkg

// [rtl/tfs_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module tfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : tfs_sync

// [rtl/tfs_top.sv]
// Fault supervisor with display choice, lamps, isolation and degraded throttle
//
// Behaviour
// [R01] Degraded switch: effort from auxiliary contacts only
// [R02] Flag defect when readings differ over 25%
// [R03] Two seconds after defect force traction zero
// [R04] Delay expiry raises a second-priority fault
// [R05] Degraded effort ramps at 20 kN/s
// [R06] Controller malfunction shows throttle isolation message
// [R07] Faults push messages without driver request
// [R08] Idle screen when fault-free or clear key
// [R09] Sixty seconds without key returns idle
// [R10] Yellow lamp lit while fault shown
// [R11] First-priority fault flashes red lamp immediately
// [R12] First-priority display withholds second-priority messages
// [R13] Second-priority message stays until replaced
// [R14] First-priority fault opens main circuit breaker
// [R15] Isolate on persistent or repeated fault
// [R16] Isolated sub-system ignored, isolation message shown
// [R17] Isolation makes red lamp steady
// [R18] Unacknowledged first-priority fault blocks travel
// [R19] Degraded demand needs zero throttle and acknowledge
`timescale 1ns/1ps
module tfs_top #(
  parameter int NUM_SS = tfs_pkg::NUM_SS,
  parameter longint unsigned DELAY_CYC = tfs_pkg::DEFECT_DELAY_CYC,
  parameter longint unsigned IDLE_CYC = tfs_pkg::IDLE_TIMEOUT_CYC,
  parameter longint unsigned WIN_CYC = tfs_pkg::REPEAT_WIN_CYC,
  parameter longint unsigned RAMP_CYC = tfs_pkg::RAMP_STEP_CYC,
  parameter longint unsigned FLASH_CYC = tfs_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_SS-1:0] fault_p1_i,
  input wire logic [NUM_SS-1:0] fault_p2_i,
  input wire tfs_pkg::tfs_keys_t keys_i,
  input wire tfs_pkg::tfs_thr_t throttle_i,
  output tfs_pkg::tfs_msg_t msg_o,
  output logic fault_ack_button_o,
  output logic red_fault_lamp_o,
  output logic main_circuit_breaker_open_o,
  output logic travel_inhibit_o,
  output logic [NUM_SS-1:0] isolated_o,
  output logic [tfs_pkg::PCT_W-1:0] effort_demand_o
);

  localparam int DW = $clog2(DELAY_CYC + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int WW = $clog2(WIN_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);
  localparam int FW = $clog2(FLASH_CYC + 1);
  localparam int SW = 2 * NUM_SS + $bits(tfs_pkg::tfs_keys_t) + $bits(tfs_pkg::tfs_thr_t);

  // Synchronised pins
  logic [SW-1:0] sync_w;
  logic [NUM_SS-1:0] p1_s, p2_s;
  tfs_pkg::tfs_keys_t keys_s;
  tfs_pkg::tfs_thr_t thr_s;

  tfs_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({fault_p1_i, fault_p2_i, keys_i, throttle_i}),
    .sync_o(sync_w)
  );
  assign {p1_s, p2_s, keys_s, thr_s} = sync_w;

  function automatic logic [tfs_pkg::SS_W-1:0] lowest(input logic [NUM_SS-1:0] v);
    logic [tfs_pkg::SS_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = tfs_pkg::SS_W'(i);
      end
    end
    return idx;
  endfunction : lowest

  function automatic logic [tfs_pkg::PCT_W-1:0] aux_level(input logic [tfs_pkg::AUX_W-1:0] a);
    logic [tfs_pkg::PCT_W-1:0] lvl;
    lvl = tfs_pkg::PCT_0;
    case (a)
      2'h1: lvl = tfs_pkg::PCT_33;
      2'h2: lvl = tfs_pkg::PCT_67;
      2'h3: lvl = tfs_pkg::PCT_100;
      default: lvl = tfs_pkg::PCT_0;
    endcase
    return lvl;
  endfunction : aux_level

  // Edge detection of faults and keys
  logic [NUM_SS-1:0] p1_q_ff, p2_q_ff;
  tfs_pkg::tfs_keys_t keys_q_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_q_ff <= '0;
      p2_q_ff <= '0;
      keys_q_ff <= '0;
    end else begin
      p1_q_ff <= p1_s;
      p2_q_ff <= p2_s;
      keys_q_ff <= keys_s;
    end
  end

  logic [NUM_SS-1:0] iso_ff, nxt_iso, p1_rise, p2_rise, win_busy, new_iso;
  logic ack_press, clear_press, menu_press, any_press;

  // [R16] Isolated inputs discarded
  assign p1_rise = p1_s & ~p1_q_ff & ~iso_ff;
  assign p2_rise = p2_s & ~p2_q_ff & ~iso_ff;
  assign ack_press = keys_s.ack & ~keys_q_ff.ack;
  assign clear_press = keys_s.clear & ~keys_q_ff.clear;
  assign menu_press = keys_s.menu & ~keys_q_ff.menu;
  assign any_press = |(keys_s & ~keys_q_ff);

  // Pending first-priority faults; a new fault wins over acknowledge
  logic [NUM_SS-1:0] p1_pend_ff;
  logic any_p1;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_pend_ff <= '0;
    end else begin
      p1_pend_ff <= (p1_pend_ff & {NUM_SS{~ack_press}}) | p1_rise;
    end
  end
  assign any_p1 = |p1_pend_ff;

  // [R14] Breaker opened while first-priority pending
  // [R18] Kept in force until acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      main_circuit_breaker_open_o <= 1'b0;
      travel_inhibit_o <= 1'b0;
    end else begin
      main_circuit_breaker_open_o <= |((p1_pend_ff & {NUM_SS{~ack_press}}) | p1_rise);
      travel_inhibit_o <= |((p1_pend_ff & {NUM_SS{~ack_press}}) | p1_rise);
    end
  end

  // [R15] Repeat window per sub-system
  logic [WW-1:0] win_cnt_ff [NUM_SS];
  for (genvar g = 0; g < NUM_SS; g++) begin : g_win
    assign win_busy[g] = (win_cnt_ff[g] != '0);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        win_cnt_ff[g] <= '0;
      end else if (p2_rise[g]) begin
        win_cnt_ff[g] <= WW'(WIN_CYC);
      end else if (win_busy[g]) begin
        win_cnt_ff[g] <= win_cnt_ff[g] - WW'(1);
      end
    end
  end

  // [R15] Persistent at acknowledge, or repeated in window
  assign nxt_iso = iso_ff | (p1_pend_ff & p1_s & {NUM_SS{ack_press}}) | (p2_rise & win_busy);
  assign new_iso = nxt_iso & ~iso_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iso_ff <= '0;
    end else begin
      iso_ff <= nxt_iso;
    end
  end
  assign isolated_o = iso_ff;

  // Throttle supervision
  logic [tfs_pkg::PCT_W-1:0] aux_lvl, angle_cap, diff;
  logic defect_det, defect_rise, defect_ff, thr_zero_ff, thr_p2_pend_ff, accept_ff;
  logic thr_expire;
  logic [DW-1:0] dly_cnt_ff;

  assign aux_lvl = aux_level(thr_s.aux);
  assign angle_cap = (thr_s.angle > tfs_pkg::PCT_100) ? tfs_pkg::PCT_100 : thr_s.angle;
  assign diff = (aux_lvl > angle_cap) ? aux_lvl - angle_cap : angle_cap - aux_lvl;
  // [R02] Mismatch check only while angle transmitter in use
  assign defect_det = ~thr_s.degraded & (diff > tfs_pkg::THR_TOL_PCT);
  assign defect_rise = defect_det & ~defect_ff;
  assign thr_expire = defect_ff & ~thr_zero_ff & (dly_cnt_ff == DW'(DELAY_CYC - 1));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      defect_ff <= 1'b0;
    end else if (defect_det) begin
      defect_ff <= 1'b1;
    end
  end

  // [R03] Delay then zero traction
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly_cnt_ff <= '0;
      thr_zero_ff <= 1'b0;
    end else if (defect_ff && !thr_zero_ff) begin
      dly_cnt_ff <= dly_cnt_ff + DW'(1);
      thr_zero_ff <= thr_expire;
    end
  end

  // [R04] Second-priority throttle fault; expiry wins over acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      thr_p2_pend_ff <= 1'b0;
    end else begin
      thr_p2_pend_ff <= thr_expire | (thr_p2_pend_ff & ~ack_press);
    end
  end

  // [R19] Accept only from zero with fault acknowledged
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accept_ff <= 1'b0;
    end else if (!thr_s.degraded) begin
      accept_ff <= 1'b0;
    end else if (aux_lvl == tfs_pkg::PCT_0 && !thr_p2_pend_ff) begin
      accept_ff <= 1'b1;
    end
  end

  // [R05] Ramp one percent per step interval
  logic [RW-1:0] ramp_cnt_ff;
  logic ramp_tick;
  assign ramp_tick = (ramp_cnt_ff == RW'(RAMP_CYC - 1));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ramp_cnt_ff <= '0;
    end else if (ramp_tick || !thr_s.degraded) begin
      ramp_cnt_ff <= '0;
    end else begin
      ramp_cnt_ff <= ramp_cnt_ff + RW'(1);
    end
  end

  // [R01] Degraded mode follows auxiliary levels only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      effort_demand_o <= tfs_pkg::PCT_0;
    end else if (!thr_s.degraded) begin
      effort_demand_o <= thr_zero_ff ? tfs_pkg::PCT_0 : angle_cap;
    end else if (!accept_ff) begin
      effort_demand_o <= tfs_pkg::PCT_0;
    end else if (ramp_tick && effort_demand_o < aux_lvl) begin
      effort_demand_o <= effort_demand_o + 7'h01;
    end else if (ramp_tick && effort_demand_o > aux_lvl) begin
      effort_demand_o <= effort_demand_o - 7'h01;
    end
  end

  // Latest pushed message; newest replaces older
  tfs_pkg::tfs_msg_t evt_ff;
  logic evt_vld_ff, new_evt;
  assign new_evt = (|new_iso) | defect_rise | thr_expire | (|p2_rise);

  // [R06] [R07] [R13] Push and hold messages
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_ff <= '{kind: tfs_pkg::MSG_IDLE, ss: '0};
      evt_vld_ff <= 1'b0;
    end else if (|new_iso) begin
      evt_ff <= '{kind: tfs_pkg::MSG_ISOL, ss: lowest(new_iso)};
      evt_vld_ff <= 1'b1;
    end else if (defect_rise) begin
      evt_ff <= '{kind: tfs_pkg::MSG_THR_ISOL, ss: '0};
      evt_vld_ff <= 1'b1;
    end else if (thr_expire) begin
      evt_ff <= '{kind: tfs_pkg::MSG_THR_P2, ss: '0};
      evt_vld_ff <= 1'b1;
    end else if (|p2_rise) begin
      evt_ff <= '{kind: tfs_pkg::MSG_P2, ss: lowest(p2_rise)};
      evt_vld_ff <= 1'b1;
    end else if (|p1_rise) begin
      evt_vld_ff <= 1'b0;
    end
  end

  // View selection; a pushed fault beats a clear in the same cycle
  logic idle_sel_ff, menu_ff, idle_expire;
  logic [IW-1:0] idle_cnt_ff;
  assign idle_expire = menu_ff & (idle_cnt_ff == IW'(IDLE_CYC));

  // [R09] Inactivity timer for the menu view
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_cnt_ff <= '0;
    end else if (any_press || !menu_ff || idle_expire) begin
      idle_cnt_ff <= '0;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + IW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      menu_ff <= 1'b0;
    end else if (new_evt || (|p1_rise) || clear_press || idle_expire) begin
      menu_ff <= 1'b0;
    end else if (menu_press) begin
      menu_ff <= 1'b1;
    end
  end

  // [R08] Clear key selects idle screen
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_sel_ff <= 1'b0;
    end else if (new_evt || (|p1_rise) || menu_press) begin
      idle_sel_ff <= 1'b0;
    end else if (clear_press || idle_expire) begin
      idle_sel_ff <= 1'b1;
    end
  end

  // [R12] First-priority message on top, below only the idle selection
  tfs_pkg::tfs_msg_t nxt_msg;
  always_comb begin
    nxt_msg = '{kind: tfs_pkg::MSG_IDLE, ss: '0};
    if (idle_sel_ff) begin
      nxt_msg = '{kind: tfs_pkg::MSG_IDLE, ss: '0};
    end else if (any_p1) begin
      nxt_msg = '{kind: tfs_pkg::MSG_P1, ss: lowest(p1_pend_ff)};
    end else if (menu_ff) begin
      nxt_msg = '{kind: tfs_pkg::MSG_MENU, ss: '0};
    end else if (evt_vld_ff) begin
      nxt_msg = evt_ff;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      msg_o <= '{kind: tfs_pkg::MSG_IDLE, ss: '0};
    end else begin
      msg_o <= nxt_msg;
    end
  end

  // Flash phase restarts lit when a first-priority message appears
  logic [FW-1:0] flash_cnt_ff;
  logic flash_on_ff, p1_enter;
  assign p1_enter = (nxt_msg.kind == tfs_pkg::MSG_P1) && (msg_o.kind != tfs_pkg::MSG_P1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flash_cnt_ff <= '0;
      flash_on_ff <= 1'b1;
    end else if (p1_enter || flash_cnt_ff == FW'(FLASH_CYC - 1)) begin
      flash_cnt_ff <= '0;
      flash_on_ff <= p1_enter | ~flash_on_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + FW'(1);
    end
  end

  // [R10] [R11] [R17] Lamp drive
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_ack_button_o <= 1'b0;
      red_fault_lamp_o <= 1'b0;
    end else begin
      fault_ack_button_o <= (nxt_msg.kind == tfs_pkg::MSG_P1) ||
                            (nxt_msg.kind == tfs_pkg::MSG_P2) ||
                            (nxt_msg.kind == tfs_pkg::MSG_THR_P2);
      red_fault_lamp_o <= (|nxt_iso) ||
                          ((nxt_msg.kind == tfs_pkg::MSG_P1) && (p1_enter || flash_on_ff));
    end
  end

  AST_DEGR_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R19]
    thr_s.degraded && !accept_ff |=> effort_demand_o == 7'h00)
    else $error("degraded demand not zero before acceptance");
  AST_DEFECT_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R02]
    defect_det |=> defect_ff)
    else $error("throttle mismatch not flagged");
  AST_ZERO_TRACTION: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R03]
    thr_zero_ff && !thr_s.degraded |=> effort_demand_o == 7'h00)
    else $error("traction not zero after defect delay");
  AST_DELAY_COUNT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R03]
    $rose(thr_zero_ff) |-> dly_cnt_ff == DW'(DELAY_CYC))
    else $error("defect delay length wrong");
  AST_THR_P2: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R04]
    $rose(thr_zero_ff) |-> thr_p2_pend_ff)
    else $error("no throttle fault at delay expiry");
  AST_THR_ISOL_MSG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R06]
    defect_rise && new_iso == '0 |=> evt_vld_ff && evt_ff.kind == tfs_pkg::MSG_THR_ISOL)
    else $error("throttle isolation message missing");
  AST_IDLE_LIMIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R09]
    idle_expire |=> !menu_ff ##1 !menu_ff && msg_o.kind != tfs_pkg::MSG_MENU)
    else $error("menu not left after inactivity");
  AST_ACK_LAMP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R10]
    msg_o.kind == tfs_pkg::MSG_P1 || msg_o.kind == tfs_pkg::MSG_P2 |-> fault_ack_button_o)
    else $error("acknowledge lamp dark during fault message");
  AST_FLASH_START: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
    msg_o.kind == tfs_pkg::MSG_P1 && $past(msg_o.kind) != tfs_pkg::MSG_P1 |-> red_fault_lamp_o)
    else $error("red lamp not lit at first-priority message");
  AST_P1_ON_TOP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R12]
    any_p1 && !idle_sel_ff |=> msg_o.kind == tfs_pkg::MSG_P1)
    else $error("first-priority message not shown");
  AST_BREAKER: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R14]
    |p1_rise |=> main_circuit_breaker_open_o && travel_inhibit_o)
    else $error("breaker not opened on first-priority fault");
  AST_REPEAT_ISO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R15]
    |(p2_rise & win_busy) |=> (iso_ff & $past(p2_rise & win_busy)) == $past(p2_rise & win_busy))
    else $error("repeated fault did not isolate");
  AST_ISO_MASK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R16]
    (p1_rise & iso_ff) == '0 && (p2_rise & iso_ff) == '0)
    else $error("isolated sub-system still reports");
  AST_ISO_STEADY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R17]
    |iso_ff |-> red_fault_lamp_o)
    else $error("red lamp not steady after isolation");
  AST_HOLD_PROTECT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R18]
    any_p1 && !ack_press |=> travel_inhibit_o && main_circuit_breaker_open_o)
    else $error("protection released without acknowledge");

endmodule : tfs_top

// [verification/tfs_console_model.sv]
// Driver's console model: keys and throttle handle
`timescale 1ns/1ps
module tfs_console_model (
  input wire logic clk_i,
  output tfs_pkg::tfs_keys_t keys_o,
  output tfs_pkg::tfs_thr_t throttle_o
);
  initial begin
    keys_o = '0;
    throttle_o = '0;
  end

  // Held three edges so the two-stage sync sees one clean press
  task automatic press(input logic [3:0] k);
    keys_o = k;
    repeat (3) @(posedge clk_i);
    #1;
    keys_o = '0;
  endtask : press

  task automatic set_thr(input logic d, input logic [1:0] a, input logic [6:0] g);
    throttle_o = '{degraded: d, aux: a, angle: g};
  endtask : set_thr
endmodule : tfs_console_model

// [verification/tb.sv]
// Self-checking bench for the traction fault supervisor
`timescale 1ns/1ps
module tb;
  localparam int DLY = 20;
  localparam int IDL = 30;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [18:0] p1 = '0;
  logic [18:0] p2 = '0;
  tfs_pkg::tfs_keys_t keys;
  tfs_pkg::tfs_thr_t thr;
  tfs_pkg::tfs_msg_t msg;
  logic yel, red, brk, inh;
  logic [18:0] iso;
  logic [6:0] eff;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  tfs_top #(.NUM_SS(19), .DELAY_CYC(DLY), .IDLE_CYC(IDL), .WIN_CYC(50), .RAMP_CYC(4),
    .FLASH_CYC(5)) tfs_top_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .fault_p1_i(p1), .fault_p2_i(p2),
    .keys_i(keys), .throttle_i(thr), .msg_o(msg), .fault_ack_button_o(yel),
    .red_fault_lamp_o(red), .main_circuit_breaker_open_o(brk),
    .travel_inhibit_o(inh), .isolated_o(iso), .effort_demand_o(eff));

  tfs_console_model tfs_console_model_inst (.clk_i(clk_i), .keys_o(keys), .throttle_o(thr));

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard: whole run needs well under this
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic key(input logic [3:0] k);
    tfs_console_model_inst.press(k);
  endtask : key

  task automatic thr_set(input logic d, input logic [1:0] a, input logic [6:0] g);
    tfs_console_model_inst.set_thr(d, a, g);
  endtask : thr_set

  // Counts red lamp changes over n cycles
  task automatic red_edges(input int n, output int c);
    logic last;
    c = 0;
    last = red;
    repeat (n) begin
      cyc(1);
      if (red !== last) c++;
      last = red;
    end
  endtask : red_edges

  task automatic t_p1();
    int c;
    p1[3] = 1'b1;
    cyc(3);
    chk("breaker", brk, 1'b1);
    chk("inhibit", inh, 1'b1);
    // Message and lamps come one edge after the breaker
    cyc(1);
    chk("msg", msg, {tfs_pkg::MSG_P1, 5'h03});
    chk("yellow", yel, 1'b1);
    chk("red", red, 1'b1);
    p2[5] = 1'b1;
    cyc(6);
    chk("msg", msg, {tfs_pkg::MSG_P1, 5'h03});
    red_edges(12, c);
    chk("flash", 16'(c > 1), 16'h0001);
    chk("inhibit", inh, 1'b1);
    // Fault still present at acknowledge, so it counts as persistent
    key(4'h8);
    chk("iso3", iso[3], 1'b1);
    chk("breaker", brk, 1'b0);
    cyc(1);
    chk("msg", msg, {tfs_pkg::MSG_ISOL, 5'h03});
    red_edges(12, c);
    chk("steady", {red, 8'(c)}, 16'h0100);
    p1[3] = 1'b0;
    cyc(4);
    p1[3] = 1'b1;
    cyc(4);
    chk("breaker", brk, 1'b0);
  endtask : t_p1

  task automatic t_p2();
    p2[7] = 1'b1;
    cyc(4);
    chk("msg", msg, {tfs_pkg::MSG_P2, 5'h07});
    cyc(10);
    chk("msg", msg, {tfs_pkg::MSG_P2, 5'h07});
    p2[8] = 1'b1;
    cyc(4);
    chk("msg", msg, {tfs_pkg::MSG_P2, 5'h08});
    p2[7] = 1'b0;
    cyc(3);
    p2[7] = 1'b1;
    cyc(4);
    chk("iso7", iso[7], 1'b1);
    chk("iso8", iso[8], 1'b0);
    chk("msg", msg, {tfs_pkg::MSG_ISOL, 5'h07});
  endtask : t_p2

  task automatic t_keys();
    // View changes two edges after the synchronised press is seen
    key(4'h4);
    cyc(1);
    chk("kind", msg.kind, tfs_pkg::MSG_IDLE);
    key(4'h2);
    cyc(1);
    chk("kind", msg.kind, tfs_pkg::MSG_MENU);
    cyc(IDL - 8);
    chk("kind", msg.kind, tfs_pkg::MSG_MENU);
    // Any key press restarts the inactivity count
    key(4'h1);
    cyc(IDL - 6);
    chk("kind", msg.kind, tfs_pkg::MSG_MENU);
    cyc(12);
    chk("kind", msg.kind, tfs_pkg::MSG_IDLE);
  endtask : t_keys

  task automatic t_thr();
    thr_set(1'b0, 2'h2, 7'h32);
    cyc(3);
    chk("effort", eff, 7'h32);
    chk("kind", msg.kind, tfs_pkg::MSG_IDLE);
    thr_set(1'b0, 2'h2, 7'h1E);
    cyc(4);
    chk("kind", msg.kind, tfs_pkg::MSG_THR_ISOL);
    cyc(DLY - 8);
    chk("effort", eff, 7'h1E);
    cyc(12);
    chk("effort", eff, 7'h00);
    chk("kind", msg.kind, tfs_pkg::MSG_THR_P2);
    chk("yellow", yel, 1'b1);
    thr_set(1'b1, 2'h3, 7'h1E);
    cyc(10);
    chk("effort", eff, 7'h00);
    thr_set(1'b1, 2'h0, 7'h00);
    cyc(1);
    key(4'h8);
    // Angle deliberately far off: degraded demand must ignore it
    thr_set(1'b1, 2'h1, 7'h5A);
    cyc(20);
    chk("ramp", 16'(eff > 0 && eff < 12), 16'h0001);
    cyc(130);
    chk("effort", eff, tfs_pkg::PCT_33);
    thr_set(1'b1, 2'h3, 7'h0A);
    cyc(20);
    chk("ramp", 16'(eff > 33 && eff < 45), 16'h0001);
    cyc(300);
    chk("effort", eff, tfs_pkg::PCT_100);
  endtask : t_thr

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    cyc(2);
    chk("kind", msg.kind, tfs_pkg::MSG_IDLE);
    chk("breaker", brk, 1'b0);
    t_p1();
    t_p2();
    t_keys();
    t_thr();
    print_verdict();
  end
endmodule : tb
